//--- src/aist_params.svh
`ifndef AIST_PARAMS_SVH
`define AIST_PARAMS_SVH

// Register byte offsets
`define AIST_OFF_STATUS     12'h000
`define AIST_OFF_IRQ_EN     12'h004
`define AIST_OFF_CONTROL    12'h008
`define AIST_OFF_CFG_ONE    12'h00C
`define AIST_OFF_CFG_TWO    12'h010
`define AIST_OFF_SMP_TIME   12'h014
`define AIST_OFF_WDG_CFG    12'h018
`define AIST_OFF_THRESH     12'h01C
`define AIST_OFF_CHSEL_LO   12'h02C
`define AIST_OFF_CHSEL_HI   12'h030
`define AIST_OFF_RESULT     12'h04C

// Status / enable bit positions
`define AIST_BIT_READY      0
`define AIST_BIT_SMP_DONE   1
`define AIST_BIT_CONV_DONE  2
`define AIST_BIT_SEQ_DONE   3
`define AIST_BIT_OVERRUN    4
`define AIST_BIT_FULL       5
`define AIST_BIT_EMPTY      6
`define AIST_BIT_WINDOW     7

// Masks of writable bits
`define AIST_IRQ_EN_MASK    8'h9F
`define AIST_W1C_MASK       8'h9F
`define AIST_CONTROL_MASK   4'hF

// Reset values
`define AIST_RST_WORD       32'h0000_0000
`define AIST_RST_BYTE       8'h00

`endif

//--- src/aist_pkg.sv
package aist_pkg;

  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  irq_en;
    logic [3:0]  control;
    logic [31:0] cfg_one;
    logic [31:0] cfg_two;
    logic [31:0] smp_time;
    logic [31:0] wdg_cfg;
    logic [31:0] thresh;
    logic [31:0] chsel_lo;
    logic [31:0] chsel_hi;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        result_pop;
    logic        enable_cmd;
  } aist_state_t;

endpackage

//--- src/aist_core.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ns
// Functional notes
// - Six event sources: ready, conv, seq, window, sample, overrun
// - Each source has its own enable bit
// - Window hit flag sticky until written one
// - Empty bit mirrors FIFO empty, ignores writes
// - Full bit mirrors FIFO full
// - Overrun set on conversion while full
// - Sequence done set at sequence end, W1C
// - Conversion flag cleared by W1C or FIFO read
// - Sampling flag set at sampling phase end
// - Ready flag set once enabled converter ready
// - Overrun enable gates overrun interrupt
// - Sequence enable gates sequence interrupt
// - Conversion enable gates conversion interrupt
// - Window enable gates window interrupt
// - Status 0x00, enables 0x04, FIFO 0x4C
// - Status bit layout seven down to zero
// - Access allowed in every processor mode
// - Sampling enable gates sampling interrupt
// - Ready enable gates ready interrupt
`include "aist_params.svh"

module aist_core (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [2:0]  pprot,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_ready,
  input  wire logic        sample_done,
  input  wire logic        conv_done,
  input  wire logic        seq_done,
  input  wire logic        window_hit,
  input  wire logic        fifo_empty,
  input  wire logic        fifo_full,
  input  wire logic [31:0] result_data,
  output logic             result_pop,
  output logic             converter_enable_cmd,
  output logic [3:0]       control_bits,
  output logic [31:0]      cfg_one_bits,
  output logic [31:0]      cfg_two_bits,
  output logic [31:0]      smp_time_bits,
  output logic [31:0]      wdg_cfg_bits,
  output logic [31:0]      thresh_bits,
  output logic [31:0]      chsel_lo_bits,
  output logic [31:0]      chsel_hi_bits,
  output logic             irq
);

  aist_pkg::aist_state_t state_reg;
  aist_pkg::aist_state_t state_next;

  logic       access;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] hw_set;
  logic [7:0] sw_clr;
  logic [7:0] flags_new;
  logic [7:0] status_view;
  logic       mapped;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Protection bits are ignored: every mode may reach every register
  assign access = psel && penable && !state_reg.pready;
  assign wr_en  = access && pwrite;
  assign rd_en  = access && !pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_mux = `AIST_RST_WORD;
    unique case (paddr)
      `AIST_OFF_STATUS:   rd_mux = {24'h00_0000, status_view};
      `AIST_OFF_IRQ_EN:   rd_mux = {24'h00_0000, state_reg.irq_en};
      `AIST_OFF_CONTROL:  rd_mux = {28'h000_0000, state_reg.control};
      `AIST_OFF_CFG_ONE:  rd_mux = state_reg.cfg_one;
      `AIST_OFF_CFG_TWO:  rd_mux = state_reg.cfg_two;
      `AIST_OFF_SMP_TIME: rd_mux = state_reg.smp_time;
      `AIST_OFF_WDG_CFG:  rd_mux = state_reg.wdg_cfg;
      `AIST_OFF_THRESH:   rd_mux = state_reg.thresh;
      `AIST_OFF_CHSEL_LO: rd_mux = state_reg.chsel_lo;
      `AIST_OFF_CHSEL_HI: rd_mux = state_reg.chsel_hi;
      `AIST_OFF_RESULT:   rd_mux = result_data;
      default:            mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Event flags
  always_comb begin
    hw_set = 8'h00;
    hw_set[`AIST_BIT_READY]     = conv_ready && state_reg.enable_cmd;
    hw_set[`AIST_BIT_SMP_DONE]  = sample_done;
    hw_set[`AIST_BIT_CONV_DONE] = conv_done;
    hw_set[`AIST_BIT_SEQ_DONE]  = seq_done;
    hw_set[`AIST_BIT_OVERRUN]   = conv_done && fifo_full;
    hw_set[`AIST_BIT_WINDOW]    = window_hit;
  end

  always_comb begin
    sw_clr = 8'h00;
    if (wr_en && paddr == `AIST_OFF_STATUS) begin
      sw_clr = pwdata[7:0] & `AIST_W1C_MASK;
    end
    // A result read also acknowledges the conversion flag
    if (rd_en && paddr == `AIST_OFF_RESULT) begin
      sw_clr[`AIST_BIT_CONV_DONE] = 1'b1;
    end
  end

  // Set wins over clear so no event is lost
  assign flags_new = ((state_reg.flags & ~sw_clr) | hw_set) & `AIST_W1C_MASK;

  // Level bits come straight from the FIFO, never stored
  always_comb begin
    status_view = state_reg.flags;
    status_view[`AIST_BIT_EMPTY] = fifo_empty;
    status_view[`AIST_BIT_FULL]  = fifo_full;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.flags      = flags_new;
    state_next.pready     = access;
    state_next.pslverr    = access && !mapped;
    state_next.result_pop = rd_en && paddr == `AIST_OFF_RESULT;
    if (rd_en) begin
      state_next.prdata = rd_mux;
    end
    if (wr_en) begin
      unique case (paddr)
        `AIST_OFF_IRQ_EN:   state_next.irq_en = pwdata[7:0] & `AIST_IRQ_EN_MASK;
        `AIST_OFF_CONTROL:  state_next.control = pwdata[3:0] & `AIST_CONTROL_MASK;
        `AIST_OFF_CFG_ONE:  state_next.cfg_one = pwdata;
        `AIST_OFF_CFG_TWO:  state_next.cfg_two = pwdata;
        `AIST_OFF_SMP_TIME: state_next.smp_time = pwdata;
        `AIST_OFF_WDG_CFG:  state_next.wdg_cfg = pwdata;
        `AIST_OFF_THRESH:   state_next.thresh = pwdata;
        `AIST_OFF_CHSEL_LO: state_next.chsel_lo = pwdata;
        `AIST_OFF_CHSEL_HI: state_next.chsel_hi = pwdata;
        default: ;
      endcase
    end
    state_next.enable_cmd = state_next.control[0];
    // Registered on the same edge as the flag so the pin is glitch free
    state_next.irq = |(flags_new & state_next.irq_en);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata               = state_reg.prdata;
  assign pready               = state_reg.pready;
  assign pslverr              = state_reg.pslverr;
  assign irq                  = state_reg.irq;
  assign result_pop           = state_reg.result_pop;
  assign converter_enable_cmd = state_reg.enable_cmd;
  assign control_bits         = state_reg.control;
  assign cfg_one_bits         = state_reg.cfg_one;
  assign cfg_two_bits         = state_reg.cfg_two;
  assign smp_time_bits        = state_reg.smp_time;
  assign wdg_cfg_bits         = state_reg.wdg_cfg;
  assign thresh_bits          = state_reg.thresh;
  assign chsel_lo_bits        = state_reg.chsel_lo;
  assign chsel_hi_bits        = state_reg.chsel_hi;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_window_set_sticky: assert property (
    @(posedge clk_sys) disable iff (reset)
    window_hit |=> state_reg.flags[`AIST_BIT_WINDOW])
    else $error("window flag not set after hit");

  a_window_hold: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_reg.flags[`AIST_BIT_WINDOW] && !(wr_en && paddr == `AIST_OFF_STATUS)
      |=> state_reg.flags[`AIST_BIT_WINDOW])
    else $error("window flag dropped without clear");

  a_overrun_cause: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(state_reg.flags[`AIST_BIT_OVERRUN]) |-> $past(conv_done && fifo_full))
    else $error("overrun set without cause");

  a_empty_mirror: assert property (
    @(posedge clk_sys) disable iff (reset)
    rd_en && paddr == `AIST_OFF_STATUS |=> prdata[`AIST_BIT_EMPTY] == $past(fifo_empty))
    else $error("empty bit does not mirror fifo");

  a_full_mirror: assert property (
    @(posedge clk_sys) disable iff (reset)
    rd_en && paddr == `AIST_OFF_STATUS |=> prdata[`AIST_BIT_FULL] == $past(fifo_full))
    else $error("full bit does not mirror fifo");

  a_seq_set: assert property (
    @(posedge clk_sys) disable iff (reset)
    seq_done |=> state_reg.flags[`AIST_BIT_SEQ_DONE])
    else $error("sequence flag missed");

  a_conv_read_clr: assert property (
    @(posedge clk_sys) disable iff (reset)
    rd_en && paddr == `AIST_OFF_RESULT && !conv_done
      |=> !state_reg.flags[`AIST_BIT_CONV_DONE])
    else $error("conversion flag not cleared by result read");

  a_sample_set: assert property (
    @(posedge clk_sys) disable iff (reset)
    sample_done |=> state_reg.flags[`AIST_BIT_SMP_DONE])
    else $error("sampling flag missed");

  a_ready_set: assert property (
    @(posedge clk_sys) disable iff (reset)
    conv_ready && converter_enable_cmd |=> state_reg.flags[`AIST_BIT_READY])
    else $error("ready flag missed");

  a_irq_gate: assert property (
    @(posedge clk_sys) disable iff (reset)
    ##1 irq == |($past(flags_new) & state_reg.irq_en))
    else $error("interrupt does not match enabled flags");

  a_overrun_irq_on: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_reg.flags[`AIST_BIT_OVERRUN] && state_reg.irq_en[`AIST_BIT_OVERRUN]
      |-> irq)
    else $error("overrun interrupt missing");

  a_no_irq_idle: assert property (
    @(posedge clk_sys) disable iff (reset)
    (state_reg.irq_en == 8'h00) |-> !irq)
    else $error("interrupt with all enables off");

  a_set_beats_clr: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_en && paddr == `AIST_OFF_STATUS && conv_done
      |=> state_reg.flags[`AIST_BIT_CONV_DONE])
    else $error("event lost under clear");

  a_pready_one: assert property (
    @(posedge clk_sys) disable iff (reset)
    psel && !penable ##1 psel && penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  ////////////////////////////////////////////////////////////////////////
  // Per-source gating, holds and clears
  a_seq_irq_on: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_reg.flags[`AIST_BIT_SEQ_DONE] && state_reg.irq_en[`AIST_BIT_SEQ_DONE] |-> irq)
    else $error("sequence interrupt missing");

  a_conv_irq_on: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_reg.flags[`AIST_BIT_CONV_DONE] && state_reg.irq_en[`AIST_BIT_CONV_DONE] |-> irq)
    else $error("conversion interrupt missing");

  a_window_irq_on: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_reg.flags[`AIST_BIT_WINDOW] && state_reg.irq_en[`AIST_BIT_WINDOW] |-> irq)
    else $error("window interrupt missing");

  a_sample_irq_on: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_reg.flags[`AIST_BIT_SMP_DONE] && state_reg.irq_en[`AIST_BIT_SMP_DONE] |-> irq)
    else $error("sampling interrupt missing");

  a_ready_irq_on: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_reg.flags[`AIST_BIT_READY] && state_reg.irq_en[`AIST_BIT_READY] |-> irq)
    else $error("ready interrupt missing");

  a_irq_quiet: assert property (
    @(posedge clk_sys) disable iff (reset)
    (state_reg.flags & state_reg.irq_en) == 8'h00 |-> !irq)
    else $error("interrupt without an enabled flag");

  a_overrun_hold: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_reg.flags[`AIST_BIT_OVERRUN] && !(wr_en && paddr == `AIST_OFF_STATUS)
      |=> state_reg.flags[`AIST_BIT_OVERRUN])
    else $error("overrun flag dropped without clear");

  a_seq_hold: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_reg.flags[`AIST_BIT_SEQ_DONE] && !(wr_en && paddr == `AIST_OFF_STATUS)
      |=> state_reg.flags[`AIST_BIT_SEQ_DONE])
    else $error("sequence flag dropped without clear");

  a_window_clear: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_en && paddr == `AIST_OFF_STATUS && pwdata[`AIST_BIT_WINDOW] && !window_hit
      |=> !state_reg.flags[`AIST_BIT_WINDOW])
    else $error("window flag not cleared by write one");

  a_conv_cause: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(state_reg.flags[`AIST_BIT_CONV_DONE]) |-> $past(conv_done))
    else $error("conversion flag set without cause");

  a_ready_cause: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(state_reg.flags[`AIST_BIT_READY]) |-> $past(conv_ready && converter_enable_cmd))
    else $error("ready flag set while converter off");

  a_pop_follows: assert property (
    @(posedge clk_sys) disable iff (reset)
    rd_en && paddr == `AIST_OFF_RESULT |=> result_pop)
    else $error("result read did not pop");

  a_any_mode: assert property (
    @(posedge clk_sys) disable iff (reset)
    access && mapped |=> pready && !pslverr)
    else $error("mapped access refused");

  a_unmapped_err: assert property (
    @(posedge clk_sys) disable iff (reset)
    access && !mapped |=> pready && pslverr)
    else $error("unmapped access not flagged");

  a_zero_write_keeps: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_en && paddr == `AIST_OFF_STATUS && (pwdata[7:0] & `AIST_W1C_MASK) == 8'h00
      |=> state_reg.flags == ($past(state_reg.flags) | $past(hw_set)))
    else $error("zero write changed a flag");

endmodule // aist_core

//--- verification/adc_interrupt_status_test.sv
`timescale 1ns/1ns
module adc_interrupt_status_test;
  logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr, irq;
  logic        fifo_empty, fifo_full;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, result_data;
  logic [2:0]  pprot;
  logic [7:0]  ev, st, en, m;
  logic        result_pop, conv_en;
  logic [3:0]  ctl;
  logic [31:0] cfgo [7];
  logic [32:0] exp_q[$];
  int          err_count, n_compared;
  localparam logic [11:0] CFG [7] = '{12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C,
                                      12'h02C, 12'h030};
  localparam int BITS [5] = '{0, 1, 2, 3, 7};

  aist_core dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_ready(ev[0]), .sample_done(ev[1]),
    .conv_done(ev[2]), .seq_done(ev[3]), .window_hit(ev[7]), .fifo_empty(fifo_empty),
    .fifo_full(fifo_full), .result_data(result_data), .result_pop(result_pop),
    .converter_enable_cmd(conv_en), .control_bits(ctl), .cfg_one_bits(cfgo[0]),
    .cfg_two_bits(cfgo[1]), .smp_time_bits(cfgo[2]), .wdg_cfg_bits(cfgo[3]),
    .thresh_bits(cfgo[4]), .chsel_lo_bits(cfgo[5]), .chsel_hi_bits(cfgo[6]), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus master: holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pprot   <= 3'($urandom);
    @(posedge clk_sys);
    penable <= 1'b1;
    // No local limit: a hang is caught by the watchdog
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge clk_sys);
    ev[b] <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  function automatic logic [32:0] stat_word();
    return {25'h0, st[7], fifo_empty, fifo_full, st[4:0]};
  endfunction

  task automatic irq_check();
    check("irq", {32'h0, irq}, {32'h0, |(st & en & 8'h9F)});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read results come back in request order, so a queue is enough
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0)
        check("read queue", 33'h0, 33'h1);
      else
        check("read word", {pslverr, prdata}, exp_q.pop_front());
    end
    if (psel && penable && pready === 1'b1) begin
      check("result pop", {32'h0, result_pop}, {32'h0, !pwrite && paddr == 12'h04C});
    end
  end

  initial begin
    #(4 * 30000);
    err_count++;
    conclude();
  end

  initial begin
    int r;
    logic [31:0] d;
    void'($urandom(32'h3ce4));
    {psel, penable, pwrite, paddr, pwdata, pprot} = '0;
    ev = 8'h00;
    st = 8'h00;
    en = 8'h00;
    fifo_empty = 1'b1;
    fifo_full = 1'b0;
    result_data = $urandom;
    reset = 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(12'h000, stat_word());
    rd(12'h004, 33'h0);
    apb(1'b1, 12'h008, 32'h0000_0001);
    check("enable out", {32'h0, conv_en}, 33'h1);
    check("control out", {29'h0, ctl}, 33'h1);
    rd(12'h008, 33'h1);
    for (int i = 0; i < 7; i++) begin
      d = $urandom;
      apb(1'b1, CFG[i], d);
      rd(CFG[i], {1'b0, d});
      check("cfg out", {1'b0, cfgo[i]}, {1'b0, d});
    end
    rd(12'h020, {1'b1, 32'h0});
    apb(1'b1, 12'h04C, 32'hFFFF_FFFF);
    rd(12'h04C, {1'b0, result_data});
    for (r = 0; r < 4; r++) begin
      en = (r == 0 || r == 3) ? 8'h9F : (r == 1) ? 8'h00 : 8'($urandom) & 8'h9F;
      fifo_full <= r[0];
      fifo_empty <= (r == 2);
      result_data <= $urandom;
      apb(1'b1, 12'h004, {24'h0, en});
      rd(12'h004, {25'h0, en});
      foreach (BITS[k]) begin
        pulse(BITS[k]);
        st[BITS[k]] = 1'b1;
        if (BITS[k] == 2) st[4] = st[4] | fifo_full;
        irq_check();
        rd(12'h000, stat_word());
      end
      apb(1'b1, 12'h000, 32'h0000_0060);
      rd(12'h000, stat_word());
      // Conversion event lands on the edge that takes the clear
      fork
        apb(1'b1, 12'h000, 32'h0000_0004);
        begin
          @(posedge clk_sys);
          ev[2] <= 1'b1;
          @(posedge clk_sys);
          ev[2] <= 1'b0;
        end
      join
      st[4] = st[4] | fifo_full;
      rd(12'h000, stat_word());
      rd(12'h04C, {1'b0, result_data});
      st[2] = 1'b0;
      irq_check();
      rd(12'h000, stat_word());
      m = 8'($urandom) & 8'h9F;
      apb(1'b1, 12'h000, {24'h0, m});
      st = st & ~m;
      irq_check();
      rd(12'h000, stat_word());
      apb(1'b1, 12'h000, 32'h0000_009F);
      st = 8'h00;
      irq_check();
      rd(12'h000, stat_word());
    end
    // Mid-run reset must drop flags, enables and the interrupt
    pulse(7);
    st[7] = 1'b1;
    irq_check();
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    st = 8'h00;
    en = 8'h00;
    irq_check();
    check("control out", {29'h0, ctl}, 33'h0);
    rd(12'h000, stat_word());
    rd(12'h004, 33'h0);
    repeat (4) @(posedge clk_sys);
    check("queue left", {1'b0, 32'(exp_q.size())}, 33'h0);
    conclude();
  end
endmodule // adc_interrupt_status_test
